/* rtl/s2ar_pkg.sv */
// Overview of operation
// - Attribute byte: bit 0 even vtotal, bits 2:1 stereo, 6:3 reserved.
// - Async clocking sends computed M; M readback stays untouched.
// - Async clocking sends derived N; N readback stays untouched.
// - Transfer-unit size reads 64 after reset.
// - Transfer-unit size bit 0 ignores writes, size always even.
// - Pixel width code 1, 2 or 4 selects pixels per clock.
// - Lane word count sets the internal words counted per line.
package s2ar_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] MISC_ATTR_OFS = 12'h528;
	localparam logic [11:0] RATIO_M_OFS = 12'h52c;
	localparam logic [11:0] TU_LEN_OFS = 12'h530;
	localparam logic [11:0] RATIO_N_OFS = 12'h534;
	localparam logic [11:0] PIX_LANES_OFS = 12'h538;
	localparam logic [11:0] LANE_WORDS_OFS = 12'h53c;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int MISC_EVEN_VT_BIT = 0;
	localparam int MISC_STEREO_LSB = 1;
	localparam int MISC_STEREO_MSB = 2;
	localparam int RATIO_MSB = 23;
	localparam int TU_MSB = 6;
	localparam int PIXW_MSB = 2;
	localparam int LANE_WORDS_MSB = 15;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [2:0] MISC_RESET = 3'h0;
	localparam logic [23:0] RATIO_RESET = 24'h000000;
	localparam logic [6:0] TU_RESET = 7'h40;
	localparam logic [2:0] PIXW_RESET = 3'h1;
	localparam logic [15:0] LANE_WORDS_RESET = 16'h0000;
	localparam logic [2:0] PIXW_ONE = 3'h1;
	localparam logic [2:0] PIXW_TWO = 3'h2;
	localparam logic [2:0] PIXW_FOUR = 3'h4;

	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_MISC = 3'h1,
		SEL_M = 3'h2,
		SEL_TU = 3'h3,
		SEL_N = 3'h4,
		SEL_PIX = 3'h5,
		SEL_WORDS = 3'h6
	} s2ar_sel_t;

	// Configuration handed to the framing logic
	typedef struct packed {
		logic even_vtotal;
		logic [1:0] stereo;
		logic [23:0] m_ratio;
		logic [23:0] n_ratio;
		logic [6:0] tu_len;
		logic pix_one;
		logic pix_two;
		logic pix_four;
		logic [15:0] lane_words;
	} s2ar_cfg_t;

	typedef enum logic [1:0] {
		WC_IDLE = 2'b00,
		WC_RUN = 2'b01
	} s2ar_wc_st_t;

endpackage

/* rtl/s2ar_word_counter.sv */
module s2ar_word_counter (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic line_start,
	input wire logic word_valid,
	input wire logic [15:0] last_index,
	output logic [15:0] word_index,
	output logic line_last
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		s2ar_pkg::s2ar_wc_st_t state;
		logic [15:0] count;
		logic last;
	} s2ar_wc_t;

	localparam s2ar_wc_t WC_RESET = '{s2ar_pkg::WC_IDLE, 16'h0000, 1'b0};

	s2ar_wc_t st;
	s2ar_wc_t next_st;

	always_comb begin
		next_st = st;
		next_st.last = 1'b0;
		case (st.state)
			s2ar_pkg::WC_IDLE: begin
				if (line_start) begin
					next_st.state = s2ar_pkg::WC_RUN;
					next_st.count = 16'h0000;
				end
			end
			s2ar_pkg::WC_RUN: begin
				// A new line restarts the count even mid-line
				if (line_start) begin
					next_st.count = 16'h0000;
				end else if (word_valid) begin
					if (st.count == last_index) begin
						next_st.last = 1'b1;
						next_st.state = s2ar_pkg::WC_IDLE;
						next_st.count = 16'h0000;
					end else begin
						next_st.count = st.count + 16'h0001;
					end
				end
			end
			default: begin
				next_st = WC_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= WC_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign word_index = st.count;
	assign line_last = st.last;

	// ****************************************
	// Checks
	// ****************************************
	AST_LINE_LAST: assert property (@(posedge clk) disable iff (sys_rst)
		line_last |-> $past(st.count) == $past(last_index) && $past(word_valid))
		else $error("line end not at programmed word count");

	COV_LINE_END: cover property (@(posedge clk) disable iff (sys_rst)
		line_start ##[1:20] line_last);

endmodule

/* rtl/s2ar_regs.sv */
module s2ar_regs (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic sync_clock_mode,
	input wire logic [23:0] async_m_value,
	input wire logic [23:0] async_n_value,
	input wire logic line_start,
	input wire logic word_valid,
	output s2ar_pkg::s2ar_cfg_t cfg,
	output logic [15:0] word_index,
	output logic line_last
);

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic s2ar_pkg::s2ar_sel_t decode_addr(
		input logic [11:0] addr
	);
		s2ar_pkg::s2ar_sel_t sel;
		sel = s2ar_pkg::SEL_NONE;
		case (addr)
			s2ar_pkg::MISC_ATTR_OFS: sel = s2ar_pkg::SEL_MISC;
			s2ar_pkg::RATIO_M_OFS: sel = s2ar_pkg::SEL_M;
			s2ar_pkg::TU_LEN_OFS: sel = s2ar_pkg::SEL_TU;
			s2ar_pkg::RATIO_N_OFS: sel = s2ar_pkg::SEL_N;
			s2ar_pkg::PIX_LANES_OFS: sel = s2ar_pkg::SEL_PIX;
			s2ar_pkg::LANE_WORDS_OFS: sel = s2ar_pkg::SEL_WORDS;
			default: sel = s2ar_pkg::SEL_NONE;
		endcase
		return sel;
	endfunction

	// Returns one, two, four pixel select bits; other codes select none
	function automatic logic [2:0] decode_pix(input logic [2:0] code);
		logic [2:0] sel;
		sel = 3'h0;
		case (code)
			s2ar_pkg::PIXW_ONE: sel = 3'h1;
			s2ar_pkg::PIXW_TWO: sel = 3'h2;
			s2ar_pkg::PIXW_FOUR: sel = 3'h4;
			default: sel = 3'h0;
		endcase
		return sel;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [2:0] misc;
		logic [23:0] m_ratio;
		logic [23:0] n_ratio;
		logic [6:1] tu_hi;
		logic [2:0] pix_width;
		logic [15:0] lane_words;
		logic [31:0] rdata;
		s2ar_pkg::s2ar_cfg_t cfg;
	} s2ar_state_t;

	localparam s2ar_pkg::s2ar_cfg_t CFG_RESET = '{
		s2ar_pkg::MISC_RESET[s2ar_pkg::MISC_EVEN_VT_BIT],
		s2ar_pkg::MISC_RESET[s2ar_pkg::MISC_STEREO_MSB:
			s2ar_pkg::MISC_STEREO_LSB],
		s2ar_pkg::RATIO_RESET,
		s2ar_pkg::RATIO_RESET,
		s2ar_pkg::TU_RESET,
		1'b1,
		1'b0,
		1'b0,
		s2ar_pkg::LANE_WORDS_RESET
	};

	localparam s2ar_state_t REG_RESET = '{
		s2ar_pkg::MISC_RESET,
		s2ar_pkg::RATIO_RESET,
		s2ar_pkg::RATIO_RESET,
		s2ar_pkg::TU_RESET[6:1],
		s2ar_pkg::PIXW_RESET,
		s2ar_pkg::LANE_WORDS_RESET,
		32'h00000000,
		CFG_RESET
	};

	s2ar_state_t st;
	s2ar_state_t next_st;
	s2ar_pkg::s2ar_sel_t wr_sel;
	s2ar_pkg::s2ar_sel_t rd_sel;
	logic [2:0] pix_sel;

	assign wr_sel = decode_addr(reg_addr);
	assign rd_sel = decode_addr(reg_addr);
	assign pix_sel = decode_pix(st.pix_width);

	// ****************************************
	// Register file and framing outputs
	// ****************************************
	always_comb begin
		next_st = st;
		// Read data stand for one cycle only
		next_st.rdata = 32'h00000000;
		if (reg_wr) begin
			case (wr_sel)
				s2ar_pkg::SEL_MISC: begin
					// Reserved bits 6:3 and bit 7 are not stored
					next_st.misc = reg_wdata[2:0];
				end
				s2ar_pkg::SEL_M: begin
					next_st.m_ratio = reg_wdata[s2ar_pkg::RATIO_MSB:0];
				end
				s2ar_pkg::SEL_TU: begin
					// Bit 0 has no storage, keeping the size even
					next_st.tu_hi = reg_wdata[s2ar_pkg::TU_MSB:1];
				end
				s2ar_pkg::SEL_N: begin
					next_st.n_ratio = reg_wdata[s2ar_pkg::RATIO_MSB:0];
				end
				s2ar_pkg::SEL_PIX: begin
					next_st.pix_width = reg_wdata[s2ar_pkg::PIXW_MSB:0];
				end
				s2ar_pkg::SEL_WORDS: begin
					next_st.lane_words =
						reg_wdata[s2ar_pkg::LANE_WORDS_MSB:0];
				end
				default: begin
					next_st.misc = st.misc;
				end
			endcase
		end
		if (reg_rd) begin
			case (rd_sel)
				s2ar_pkg::SEL_MISC: next_st.rdata = {29'h0, st.misc};
				s2ar_pkg::SEL_M: next_st.rdata = {8'h00, st.m_ratio};
				s2ar_pkg::SEL_TU: next_st.rdata = {25'h0, st.tu_hi, 1'b0};
				s2ar_pkg::SEL_N: next_st.rdata = {8'h00, st.n_ratio};
				s2ar_pkg::SEL_PIX: next_st.rdata = {29'h0, st.pix_width};
				s2ar_pkg::SEL_WORDS: next_st.rdata = {16'h0, st.lane_words};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		next_st.cfg.even_vtotal = st.misc[s2ar_pkg::MISC_EVEN_VT_BIT];
		next_st.cfg.stereo =
			st.misc[s2ar_pkg::MISC_STEREO_MSB:s2ar_pkg::MISC_STEREO_LSB];
		// Computed ratios go to the stream, never to the registers
		if (sync_clock_mode) begin
			next_st.cfg.m_ratio = st.m_ratio;
			next_st.cfg.n_ratio = st.n_ratio;
		end else begin
			next_st.cfg.m_ratio = async_m_value;
			next_st.cfg.n_ratio = async_n_value;
		end
		next_st.cfg.tu_len = {st.tu_hi, 1'b0};
		// Unknown width codes select no input width at all
		next_st.cfg.pix_one = pix_sel[0];
		next_st.cfg.pix_two = pix_sel[1];
		next_st.cfg.pix_four = pix_sel[2];
		next_st.cfg.lane_words = st.lane_words;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= REG_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign cfg = st.cfg;

	// ****************************************
	// Per-line word counting
	// ****************************************
	s2ar_word_counter u_word_counter (
		.clk(clk),
		.sys_rst(sys_rst),
		.line_start(line_start),
		.word_valid(word_valid),
		.last_index(st.lane_words),
		.word_index(word_index),
		.line_last(line_last)
	);

	// ****************************************
	// Checks
	// ****************************************
	logic tu_written;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tu_written <= 1'b0;
		end else if (reg_wr && wr_sel == s2ar_pkg::SEL_TU) begin
			tu_written <= 1'b1;
		end
	end

	AST_MISC_LAYOUT: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_wr && wr_sel == s2ar_pkg::SEL_MISC ##1 1'b1 ##1 1'b1 |->
		cfg.even_vtotal == $past(reg_wdata[0], 2) &&
		cfg.stereo == $past(reg_wdata[2:1], 2))
		else $error("attribute byte fields misplaced");

	// Release edge still resets cfg, so no ratio is expected there
	AST_M_ASYNC: assert property (@(posedge clk) disable iff (sys_rst)
		!sys_rst && !sync_clock_mode ##1 1'b1 |->
		cfg.m_ratio == $past(async_m_value))
		else $error("computed M not sent in async mode");

	AST_M_READBACK: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && rd_sel == s2ar_pkg::SEL_M && !sync_clock_mode |=>
		reg_rdata == {8'h00, $past(st.m_ratio)})
		else $error("M readback shows computed value");

	AST_N_ASYNC: assert property (@(posedge clk) disable iff (sys_rst)
		!sys_rst && !sync_clock_mode && !reg_wr ##1 !sync_clock_mode |->
		cfg.n_ratio == $past(async_n_value) && st.n_ratio == $past(st.n_ratio))
		else $error("derived N handled wrongly");

	AST_TU_RESET: assert property (@(posedge clk) disable iff (sys_rst)
		!tu_written && !$past(tu_written) |-> cfg.tu_len == s2ar_pkg::TU_RESET)
		else $error("transfer unit size not 64 after reset");

	AST_TU_EVEN: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && wr_sel == s2ar_pkg::SEL_TU ##1 !reg_wr ##1 1'b1 |->
		cfg.tu_len == {$past(reg_wdata[6:1], 2), 1'b0})
		else $error("transfer unit size bit 0 written");

	AST_PIX_DECODE: assert property (@(posedge clk) disable iff (sys_rst)
		##1 1'b1 |-> cfg.pix_four == ($past(st.pix_width) == 3'h4) &&
		cfg.pix_two == ($past(st.pix_width) == 3'h2) &&
		cfg.pix_one == ($past(st.pix_width) == 3'h1))
		else $error("pixel width decode wrong");

	AST_RDATA_ONE_CYCLE: assert property (@(posedge clk)
		disable iff (sys_rst)
		!reg_rd || rd_sel == s2ar_pkg::SEL_NONE |=> reg_rdata == 32'h0)
		else $error("read data outside a mapped read");

	AST_RSV_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && rd_sel == s2ar_pkg::SEL_MISC |=> reg_rdata[31:3] == 29'h0)
		else $error("reserved attribute bits read nonzero");

	AST_PIX_RSV_ZERO: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_rd && rd_sel == s2ar_pkg::SEL_PIX |=> reg_rdata[31:3] == 29'h0)
		else $error("unused pixel width bits read nonzero");

	AST_WORDS_RSV_ZERO: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_rd && rd_sel == s2ar_pkg::SEL_WORDS |=>
		reg_rdata[31:16] == 16'h0)
		else $error("unused word count bits read nonzero");

	AST_RATIO_RSV_ZERO: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_rd &&
		(rd_sel == s2ar_pkg::SEL_M || rd_sel == s2ar_pkg::SEL_N) |=>
		reg_rdata[31:24] == 8'h00)
		else $error("unused ratio bits read nonzero");

	AST_TU_READ_EVEN: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_rd && rd_sel == s2ar_pkg::SEL_TU |=>
		reg_rdata[0] == 1'b0 && reg_rdata[31:7] == 25'h0)
		else $error("transfer unit size read odd or wide");

	AST_N_READBACK: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_rd && rd_sel == s2ar_pkg::SEL_N && !sync_clock_mode |=>
		reg_rdata == {8'h00, $past(st.n_ratio)})
		else $error("N readback shows derived value");

	// Only a software write may move the stored ratios
	AST_M_HOLD: assert property (@(posedge clk)
		disable iff (sys_rst)
		!(reg_wr && wr_sel == s2ar_pkg::SEL_M) |=>
		st.m_ratio == $past(st.m_ratio))
		else $error("M register changed without a write");

	AST_N_HOLD: assert property (@(posedge clk)
		disable iff (sys_rst)
		!(reg_wr && wr_sel == s2ar_pkg::SEL_N) |=>
		st.n_ratio == $past(st.n_ratio))
		else $error("N register changed without a write");

	AST_UNMAPPED_WRITE: assert property (@(posedge clk)
		disable iff (sys_rst)
		reg_wr && wr_sel == s2ar_pkg::SEL_NONE |=>
		st.misc == $past(st.misc) &&
		st.tu_hi == $past(st.tu_hi) &&
		st.m_ratio == $past(st.m_ratio) &&
		st.n_ratio == $past(st.n_ratio) &&
		st.pix_width == $past(st.pix_width) &&
		st.lane_words == $past(st.lane_words))
		else $error("unmapped write changed a register");

	AST_LANE_WORDS_CFG: assert property (@(posedge clk)
		disable iff (sys_rst)
		##1 1'b1 |-> cfg.lane_words == $past(st.lane_words))
		else $error("lane word count not passed on");

	// Width selects must never fight each other
	AST_PIX_ONEHOT: assert property (@(posedge clk)
		disable iff (sys_rst)
		$onehot0({cfg.pix_four, cfg.pix_two, cfg.pix_one}))
		else $error("more than one pixel width selected");

	COV_TU_WRITE: cover property (@(posedge clk) disable iff (sys_rst)
		reg_wr && wr_sel == s2ar_pkg::SEL_TU ##2 reg_rd);

	COV_ASYNC: cover property (@(posedge clk) disable iff (sys_rst)
		!sync_clock_mode && reg_rd && rd_sel == s2ar_pkg::SEL_N);

	COV_QUAD: cover property (@(posedge clk) disable iff (sys_rst)
		cfg.pix_four);

endmodule

/* sim/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Signals and instance
	// ****************************************
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [31:0] rexp;
	} s2ar_tb_row_t;

	logic clk;
	logic sys_rst;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic sync_clock_mode;
	logic [23:0] async_m_value;
	logic [23:0] async_n_value;
	logic line_start;
	logic word_valid;
	s2ar_pkg::s2ar_cfg_t cfg;
	logic [15:0] word_index;
	logic line_last;
	int error_cnt;
	int compares;
	logic [31:0] rv;

	s2ar_tb_row_t rows [9] = '{
		'{12'h528, 32'hffffffff, 32'h00000007},
		'{12'h52c, 32'hffabcdef, 32'h00abcdef},
		'{12'h530, 32'h0000007f, 32'h0000007e},
		'{12'h530, 32'h00000030, 32'h00000030},
		'{12'h530, 32'hffffff21, 32'h00000020},
		'{12'h534, 32'h12345678, 32'h00345678},
		'{12'h538, 32'hfffffffa, 32'h00000002},
		'{12'h53c, 32'hdead1234, 32'h00001234},
		'{12'h600, 32'hffffffff, 32'h00000000}
	};

	s2ar_regs i_s2ar_regs (
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.sync_clock_mode(sync_clock_mode),
		.async_m_value(async_m_value),
		.async_n_value(async_n_value),
		.line_start(line_start),
		.word_valid(word_valid),
		.cfg(cfg),
		.word_index(word_index),
		.line_last(line_last)
	);

	always #25 clk = ~clk;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask

	task automatic pulse(input logic ls);
		@(posedge clk);
		line_start <= ls;
		word_valid <= ~ls;
		@(posedge clk);
		line_start <= 1'b0;
		word_valid <= 1'b0;
		@(negedge clk);
	endtask

	// Expected count the way software derives it per lane
	function automatic logic [15:0] lane_cnt(int p, int b, int l);
		int w;
		w = (p * b) / 16 + (((p * b) % 16) != 0);
		if (l == 1) begin
			return 16'(w - 1);
		end
		return 16'(((w % l) == 0) ? (w - l) : (w + (w % l) - l));
	endfunction

	// Stray words must not end a line; then one full line
	task automatic line_run(input logic [15:0] cnt);
		wr(s2ar_pkg::LANE_WORDS_OFS, {16'h0, cnt});
		pulse(1'b0);
		cmp({31'h0, line_last}, 32'h0);
		cmp({16'h0, cfg.lane_words}, {16'h0, cnt});
		pulse(1'b1);
		for (int i = 0; i <= int'(cnt); i++) begin
			pulse(1'b0);
			cmp({31'h0, line_last}, {31'h0, i == int'(cnt)});
			cmp({16'h0, word_index}, (i == int'(cnt)) ? 32'h0 : 32'(i + 1));
		end
		cmp({16'h0, word_index}, 32'h0);
		pulse(1'b0);
		cmp({31'h0, line_last}, 32'h0);
	endtask

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		complete_run();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 12'h000;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sync_clock_mode = 1'b1;
		async_m_value = 24'h111111;
		async_n_value = 24'h222222;
		line_start = 1'b0;
		word_valid = 1'b0;
		error_cnt = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(s2ar_pkg::TU_LEN_OFS, rv);
		cmp(rv, 32'h40);
		cmp({25'h0, cfg.tu_len}, 32'h40);
		rd(s2ar_pkg::PIX_LANES_OFS, rv);
		cmp(rv, 32'h1);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rv);
			cmp(rv, rows[i].rexp);
		end
		// Synchronous clocking sends the programmed ratios
		cmp({8'h0, cfg.m_ratio}, 32'h00abcdef);
		cmp({8'h0, cfg.n_ratio}, 32'h00345678);
		cmp({29'h0, cfg.even_vtotal, cfg.stereo}, 32'h7);
		cmp({25'h0, cfg.tu_len}, 32'h20);
		// Asynchronous clocking: sent value differs, readback kept
		@(posedge clk);
		sync_clock_mode <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp({8'h0, cfg.m_ratio}, 32'h00111111);
		cmp({8'h0, cfg.n_ratio}, 32'h00222222);
		rd(s2ar_pkg::RATIO_M_OFS, rv);
		cmp(rv, 32'h00abcdef);
		rd(s2ar_pkg::RATIO_N_OFS, rv);
		cmp(rv, 32'h00345678);
		// Width codes 0 to 7, illegal ones included
		for (int c = 0; c < 8; c++) begin
			wr(s2ar_pkg::PIX_LANES_OFS, 32'(c));
			repeat (2) @(posedge clk);
			@(negedge clk);
			cmp({29'h0, cfg.pix_four, cfg.pix_two, cfg.pix_one},
				{29'h0, c == 4, c == 2, c == 1});
		end
		line_run(lane_cnt(9, 16, 1));
		line_run(lane_cnt(7, 24, 2));
		line_run(lane_cnt(10, 24, 2));
		line_run(lane_cnt(5, 16, 4));
		// Back-to-back reads; data stands one cycle only
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= s2ar_pkg::TU_LEN_OFS;
		@(posedge clk);
		reg_addr <= s2ar_pkg::MISC_ATTR_OFS;
		@(negedge clk);
		cmp(reg_rdata, 32'h20);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		cmp(reg_rdata, 32'h7);
		@(negedge clk);
		cmp(reg_rdata, 32'h0);
		// Second reset in mid-run restores the size
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(s2ar_pkg::TU_LEN_OFS, rv);
		cmp(rv, 32'h40);
		cmp({25'h0, cfg.tu_len}, 32'h40);
		complete_run();
	end
endmodule
